// ---- rtl/prc_map.svh ----
// Purpose: Offsets, field positions and reset values of the pin router.
// Assumes: Special function addresses are eight bits wide.
// Notes: Definitions only.
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
`define PRC_ADDR_FIRST 8'hE2
`define PRC_ADDR_SECOND 8'hE3
`define PRC_RST_FIRST 8'h00
`define PRC_RST_SECOND 8'h00
`define PRC_SECOND_MASK 8'hC1
`define PRC_BIT_PULLUP_DIS 7
`define PRC_BIT_MATRIX_EN 6
`define PRC_BIT_CONV_EN 0
`define PRC_NUM_PINS 24
`define PRC_NUM_SIG 9
`endif

// ---- rtl/prc_pkg.sv ----
// Purpose: Types shared by the pin router files.
// Assumes: Nine routable signals, 24 port pins.
// Notes: Signal order is the pin claiming priority, index 0 first.
package prc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } prc_sfr_req_type;
    typedef enum logic [0:0] {
        PRC_PIN_GPIO = 1'b0,
        PRC_PIN_PERIPH = 1'b1
    } prc_pin_mode_type;
endpackage : prc_pkg

// ---- rtl/prc_slot.sv ----
// Purpose: Claims the next free pin for one routed signal.
// Assumes: Pins are claimed in ascending order.
// Notes: Chained once per signal in priority order.
module prc_slot (
    // Chain
    input wire logic [4:0] base_in,
    input wire logic enable,
    output logic [4:0] base_out,
    output logic valid
);
    always_comb
    begin
        valid = enable && (base_in < 5'h18);
        base_out = valid ? (base_in + 5'h01) : base_in;
    end
endmodule : prc_slot

// ---- rtl/prc_router.sv ----
// Purpose: Pin routing control registers and priority pin assignment.
// Assumes: Base enable count comes in already resolved; pins synchronous.
// Notes: Peripherals given by the base register claim pins first.
`include "prc_map.svh"
module prc_router (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Special function register access
    input wire prc_pkg::prc_sfr_req_type SFR_REQ,
    output logic [7:0] SFR_RDATA,
    // Pins claimed ahead by the base register
    input wire logic [4:0] BASE_USED,
    // Port latches, pin levels and read mode
    input wire logic [23:0] PORT_LATCH,
    input wire logic [23:0] PIN_LEVEL,
    input wire logic RMW_READ,
    output logic [23:0] PORT_READ,
    // Peripheral signals
    input wire logic CORE_CLOCK_OUT,
    input wire logic CMP_ONE_OUTPUT,
    output logic TIMER2_CAPTURE_INPUT,
    output logic TIMER2_INPUT,
    output logic EXT_IRQ_ONE_INPUT,
    output logic TIMER1_INPUT,
    output logic EXT_IRQ_ZERO_INPUT,
    output logic TIMER0_INPUT,
    output logic ADC_CONV_START_INPUT,
    // Pin drive
    output logic [23:0] PIN_OUT,
    output logic [23:0] PIN_OE,
    output logic [23:0] PIN_PERIPH,
    output logic PULLUP_ENABLE
);
    logic [7:0] first_q, first_d, second_q, second_d, rdata_d;
    logic [8:0] sig_en, sig_valid;
    logic [4:0] chain [0:9];
    logic [4:0] pin_of [0:8];
    logic route_en;

    always_comb
    begin
        first_d = first_q;
        second_d = second_q;
        if (SFR_REQ.wr && SFR_REQ.addr == `PRC_ADDR_FIRST)
        begin
            first_d = SFR_REQ.wdata;
        end
        if (SFR_REQ.wr && SFR_REQ.addr == `PRC_ADDR_SECOND)
        begin
            second_d = SFR_REQ.wdata & `PRC_SECOND_MASK;
        end
        rdata_d = 8'h00;
        if (SFR_REQ.rd && SFR_REQ.addr == `PRC_ADDR_FIRST)
        begin
            rdata_d = first_q;
        end
        if (SFR_REQ.rd && SFR_REQ.addr == `PRC_ADDR_SECOND)
        begin
            rdata_d = second_q;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            first_q <= `PRC_RST_FIRST;
            second_q <= `PRC_RST_SECOND;
            SFR_RDATA <= 8'h00;
        end
        else
        begin
            first_q <= first_d;
            second_q <= second_d;
            SFR_RDATA <= rdata_d;
        end
    end

    // Priority order follows the decode table, most urgent first.
    assign route_en = second_q[`PRC_BIT_MATRIX_EN];
    assign sig_en = {second_q[`PRC_BIT_CONV_EN], first_q[7:0]} &
                    {9{route_en}};
    assign chain[0] = BASE_USED;
    assign PULLUP_ENABLE = ~second_q[`PRC_BIT_PULLUP_DIS];

    genvar g;
    generate
        for (g = 0; g < `PRC_NUM_SIG; g++)
        begin : g_slot
            // Bit order 0..7 is comparator first, clock output last.
            prc_slot u_slot (
                .base_in(chain[g]),
                .enable(sig_en[g]),
                .base_out(chain[g + 1]),
                .valid(sig_valid[g])
            );
            assign pin_of[g] = chain[g];
        end
    endgenerate

    // Output drivers: clock out at bit 7, comparator at bit 0.
    always_comb
    begin
        PIN_OUT = PORT_LATCH;
        PIN_PERIPH = 24'h000000;
        TIMER0_INPUT = 1'b1;
        EXT_IRQ_ZERO_INPUT = 1'b1;
        TIMER1_INPUT = 1'b1;
        EXT_IRQ_ONE_INPUT = 1'b1;
        TIMER2_INPUT = 1'b1;
        TIMER2_CAPTURE_INPUT = 1'b1;
        ADC_CONV_START_INPUT = 1'b1;
        for (int i = 0; i < `PRC_NUM_SIG; i++)
        begin
            if (sig_valid[i])
            begin
                PIN_PERIPH[pin_of[i]] = 1'b1;
            end
        end
        if (sig_valid[0])
        begin
            PIN_OUT[pin_of[0]] = CMP_ONE_OUTPUT;
        end
        if (sig_valid[7])
        begin
            PIN_OUT[pin_of[7]] = CORE_CLOCK_OUT;
        end
        if (sig_valid[1])
        begin
            TIMER0_INPUT = PIN_LEVEL[pin_of[1]];
        end
        if (sig_valid[2])
        begin
            EXT_IRQ_ZERO_INPUT = PIN_LEVEL[pin_of[2]];
        end
        if (sig_valid[3])
        begin
            TIMER1_INPUT = PIN_LEVEL[pin_of[3]];
        end
        if (sig_valid[4])
        begin
            EXT_IRQ_ONE_INPUT = PIN_LEVEL[pin_of[4]];
        end
        if (sig_valid[5])
        begin
            TIMER2_INPUT = PIN_LEVEL[pin_of[5]];
        end
        if (sig_valid[6])
        begin
            TIMER2_CAPTURE_INPUT = PIN_LEVEL[pin_of[6]];
        end
        if (sig_valid[8])
        begin
            ADC_CONV_START_INPUT = PIN_LEVEL[pin_of[8]];
        end
        // Input signals leave the pin released, whatever the latch holds.
        PIN_OE = ~PIN_PERIPH | {24{1'b0}};
        for (int i = 1; i < 7; i++)
        begin
            if (sig_valid[i])
            begin
                PIN_OE[pin_of[i]] = 1'b0;
            end
        end
        if (sig_valid[8])
        begin
            PIN_OE[pin_of[8]] = 1'b0;
        end
        if (sig_valid[0])
        begin
            PIN_OE[pin_of[0]] = 1'b1;
        end
        if (sig_valid[7])
        begin
            PIN_OE[pin_of[7]] = 1'b1;
        end
    end

    // Pin reads ignore the routing; software sees the pad, or the latch when RMW_READ is set.
    assign PORT_READ = RMW_READ ? PORT_LATCH : PIN_LEVEL;

    reg_reset_a: assert property (
        @(posedge CORE_CLK)
        !RST_B |=> first_q == 8'h00 && second_q == 8'h00)
        else $error("Routing registers not cleared by reset.");
    unused_bits_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        second_q[5:1] == 5'h00)
        else $error("Unused bits of second register not zero.");
    write_first_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        SFR_REQ.wr && SFR_REQ.addr == `PRC_ADDR_FIRST
        |=> first_q == $past(SFR_REQ.wdata))
        else $error("First register write lost.");
    matrix_off_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        !route_en |-> PIN_PERIPH == 24'h000000)
        else $error("Pin assigned while matrix disabled.");
    pullup_ctl_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        SFR_REQ.wr && SFR_REQ.addr == `PRC_ADDR_SECOND
        |=> PULLUP_ENABLE == !$past(SFR_REQ.wdata[7]))
        else $error("Pull-up control wrong.");
    gpio_pin_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        PIN_PERIPH == 24'h000000 |-> PIN_OUT == PORT_LATCH)
        else $error("Free pin not driven from latch.");
    first_pin_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        route_en && first_q[0] && BASE_USED == 5'h00 |-> PIN_PERIPH[0])
        else $error("First signal did not take pin zero.");
    conv_route_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        !second_q[0] |-> ADC_CONV_START_INPUT)
        else $error("Convert start reached while unrouted.");
    port_read_a: assert property (
        @(posedge CORE_CLK) disable iff (!RST_B)
        !RMW_READ |-> PORT_READ == PIN_LEVEL)
        else $error("Port read did not return pin levels.");
    route_on_c: cover property (@(posedge CORE_CLK) route_en && |first_q);
    conv_on_c: cover property (@(posedge CORE_CLK) sig_valid[8]);
    pull_off_c: cover property (@(posedge CORE_CLK) !PULLUP_ENABLE);
endmodule : prc_router

// ---- sim/prc_pins.sv ----
// Purpose: Pads and outside drivers facing the pin router.
// Assumes: An undriven pad follows what the outside world puts on it.
// Notes: The outside level differs from the latch, so a lost drive shows.
module prc_pins (
    // Router drive
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe,
    // Outside world
    input wire logic [23:0] ext_level,
    output logic [23:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // A driving pad wins, so routed outputs are seen back at the pins.
    always_comb pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : prc_pins

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the pin router.
// Assumes: Inputs change at the falling clock edge.
// Notes: Read data is compared one cycle after the request.
`include "prc_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, rmw, cko, cmp, t2c, t2, ie1, t1, ie0, t0, cnv, pue;
    prc_pkg::prc_sfr_req_type req;
    logic [7:0] rdata;
    logic [4:0] base;
    logic [23:0] latch, lvl, ext, pread, pout, poe, pper;
    int error_cnt, comparisons, cyc;
    prc_router i_prc_router (.CORE_CLK(clk), .RST_B(rst_b), .SFR_REQ(req),
        .SFR_RDATA(rdata), .BASE_USED(base), .PORT_LATCH(latch),
        .PIN_LEVEL(lvl), .RMW_READ(rmw), .PORT_READ(pread),
        .CORE_CLOCK_OUT(cko), .CMP_ONE_OUTPUT(cmp),
        .TIMER2_CAPTURE_INPUT(t2c), .TIMER2_INPUT(t2),
        .EXT_IRQ_ONE_INPUT(ie1), .TIMER1_INPUT(t1),
        .EXT_IRQ_ZERO_INPUT(ie0), .TIMER0_INPUT(t0),
        .ADC_CONV_START_INPUT(cnv), .PIN_OUT(pout), .PIN_OE(poe),
        .PIN_PERIPH(pper), .PULLUP_ENABLE(pue));
    prc_pins i_prc_pins (.pin_out(pout), .pin_oe(poe), .ext_level(ext),
        .pin_level(lvl));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string name, input logic [23:0] seen,
        input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        req.rd = 1'b0;
        check("register read", 24'(rdata), 24'(exp));
    endtask : rd
    task automatic test_done();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // The ceiling sits far above the fifty or so cycles the tests need.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            error_cnt++;
            test_done();
        end
    end
    initial
    begin
        rst_b = 1'b0;
        req = '0;
        base = 5'h00;
        {rmw, cko, cmp} = 3'h0;
        latch = 24'hA5C3E1;
        ext = 24'h5A3C1E;
        error_cnt = 0;
        comparisons = 0;
        cyc = 0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        rd(`PRC_ADDR_FIRST, 8'h00);
        rd(`PRC_ADDR_SECOND, 8'h00);
        check("pullup", 24'(pue), 24'h000001);
        check("periph", pper, 24'h000000);
        check("pin read", pread, lvl);
        rmw = 1'b1;
        @(negedge clk);
        check("latch read", pread, latch);
        rmw = 1'b0;
        wr(`PRC_ADDR_SECOND, 8'hFF);
        rd(`PRC_ADDR_SECOND, 8'hC1);
        check("pullup", 24'(pue), 24'h000000);
        check("conv pin", pper, 24'h000001);
        check("conv in", 24'(cnv), 24'(ext[0]));
        wr(`PRC_ADDR_FIRST, 8'hFF);
        rd(`PRC_ADDR_FIRST, 8'hFF);
        check("all nine", pper, 24'h0001FF);
        check("drive", 24'({poe[7], poe[0], pout[7], pout[0]}), 24'hC);
        check("inputs", 24'({t0, ie0, t1, ie1, t2, t2c, cnv}),
            24'({ext[1], ext[2], ext[3], ext[4], ext[5], ext[6], ext[8]}));
        check("gpio", 24'(pout[23:9]), 24'(latch[23:9]));
        // Routed input pins now differ from the latch, so both paths show.
        check("pin read routed", pread, 24'hA5C21E);
        rmw = 1'b1;
        @(negedge clk);
        check("latch read routed", pread, 24'hA5C3E1);
        rmw = 1'b0;
        // Only four pins stay free after the base claim, so five signals lose.
        base = 5'd20;
        @(negedge clk);
        check("late pins", pper, 24'hF00000);
        check("gpio low", 24'(pout[19:0]), 24'(latch[19:0]));
        base = 5'h00;
        wr(`PRC_ADDR_SECOND, 8'h3E);
        rd(`PRC_ADDR_SECOND, 8'h00);
        check("off", pper, 24'h000000);
        check("unrouted", 24'({t0, ie0, t1, ie1, t2, t2c, cnv}), 24'h7F);
        check("pullup", 24'(pue), 24'h000001);
        wr(8'hE4, 8'h55);
        rd(`PRC_ADDR_FIRST, 8'hFF);
        rd(8'hE4, 8'h00);
        wr(`PRC_ADDR_SECOND, 8'hC0);
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        rd(`PRC_ADDR_FIRST, 8'h00);
        rd(`PRC_ADDR_SECOND, 8'h00);
        check("pullup after reset", 24'(pue), 24'h000001);
        check("periph after reset", pper, 24'h000000);
        test_done();
    end
endmodule : tb_top
